// >>> hdl/fes_pkg.sv
// How it works
// - A page erase clears exactly one 512-byte page and leaves every other byte untouched.
// - After a page erase every byte of that page reads back as ff.
// - The page comes from the page select input, and a page in a protected sector is refused.
// - Writing 95 to the control register while unlocked with a page selected starts a page erase.
// - During any erase the core is held idle while clock and peripherals run, then released.
// - A finished page erase relocks the controller.
// - Mass erase is accepted only from the debugger, never from core code.
// - Writing 63 while unlocked with mass erase enabled starts a mass erase.
// - After a mass erase every byte of the whole array reads back as ff.
// - A finished mass erase relocks the controller.
// - In bypass mode the flash control signals are routed to the GPIO pins.
// - Page erase still works while the controller is bypassed.
`default_nettype none
package fes_pkg;
   // -----------------------------------------
   // Commands, geometry and timing
   // -----------------------------------------
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int PAGE_BYTES = 512;
   localparam int CLK_HZ = 10000000;
   localparam int PAGE_ERASE_US = 10;
   localparam int MASS_ERASE_US = 20;
   localparam int PAGE_ERASE_CYC = (PAGE_ERASE_US * (CLK_HZ / 1000000) > 0) ?
      PAGE_ERASE_US * (CLK_HZ / 1000000) : 1;
   localparam int MASS_ERASE_CYC = (MASS_ERASE_US * (CLK_HZ / 1000000) > 0) ?
      MASS_ERASE_US * (CLK_HZ / 1000000) : 1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PAGE = 2'b01,
      ST_MASS = 2'b10
   } fes_state_t;
endpackage
`default_nettype wire

// >>> hdl/fes_sync.sv
`default_nettype none
module fes_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage1;
   // Two flops; stage1 is read only by synced
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '0;
         synced <= '0;
      end else begin
         stage1 <= async;
         synced <= stage1;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/flash_erase_sequencer.sv
`default_nettype none
module fes_flash_erase_sequencer
   import fes_pkg::*;
#(
   parameter int PAGES = 8,
   parameter int SECTORS = 4,
   parameter int PAGE_CYC = fes_pkg::PAGE_ERASE_CYC,
   parameter int MASS_CYC = fes_pkg::MASS_ERASE_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   // Control register write port
   input wire logic ctrlWrite,
   input wire logic [7:0] ctrlData,
   input wire logic fromDebugger,
   input wire logic unlockReq,
   input wire logic massEnable,
   input wire logic pageValid,
   input wire logic [$clog2(PAGES)-1:0] pageSelect,
   input wire logic [SECTORS-1:0] sectorProtect,
   // Byte read port
   input wire logic [$clog2(PAGES*fes_pkg::PAGE_BYTES)-1:0] readAddr,
   output logic [7:0] readData,
   // Byte program port (clears bits)
   input wire logic progWrite,
   input wire logic [$clog2(PAGES*fes_pkg::PAGE_BYTES)-1:0] progAddr,
   input wire logic [7:0] progData,
   // Bypass pins
   input wire logic bypassPin,
   input wire logic extErasePin,
   input wire logic extProgPin,
   output logic gpioFlashBusy,
   output logic unlocked,
   output logic eraseBusy,
   output logic eraseDone,
   output logic refused,
   output logic coreStall
);
   import fes_pkg::*;
   localparam int AW = $clog2(PAGES * PAGE_BYTES);
   localparam int PW = $clog2(PAGES);
   localparam int CW = $clog2((PAGE_CYC > MASS_CYC ? PAGE_CYC : MASS_CYC) + 1);

   // Refuse sizes that the page and sector arithmetic cannot serve
   if (PAGES < 2 || SECTORS < 1 || SECTORS > PAGES || PAGES % SECTORS != 0
      || PAGE_CYC < 1 || MASS_CYC < 1) begin : g_bad_params
      $error("fes: unsupported parameters");
   end

   // -----------------------------------------
   // Storage and synchronised pins
   // -----------------------------------------
   logic [7:0] mem [PAGES*PAGE_BYTES];
   logic [2:0] pinSync;
   logic bypass, extErase, extProg;
   fes_sync #(.WIDTH(3)) fes_sync_inst (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .async({bypassPin, extErasePin, extProgPin}),
      .synced(pinSync)
   );
   assign bypass = pinSync[2];
   assign extErase = pinSync[1];
   assign extProg = pinSync[0];

   function automatic logic sector_locked(input logic [PW-1:0] pg,
                                          input logic [SECTORS-1:0] prot);
      sector_locked = prot[pg / (PAGES / SECTORS)];
   endfunction

   // -----------------------------------------
   // Command decode
   // -----------------------------------------
   fes_state_t state;
   logic [CW-1:0] count;
   logic [PW-1:0] erasePage;
   logic extEraseLast;
   logic pageCmd, massCmd, extPageCmd, pageOk, startPage, startMass, finish;
   logic pageReq, massReq;
   assign pageCmd = ctrlWrite && ctrlData == CMD_PAGE_ERASE;
   assign massCmd = ctrlWrite && ctrlData == CMD_MASS_ERASE;
   // Bypassed erase: external programmer pulses its erase pin
   assign extPageCmd = bypass && extErase && !extEraseLast;
   assign pageOk = pageValid && !sector_locked(pageSelect, sectorProtect);
   assign pageReq = state == ST_IDLE && pageCmd && unlocked;
   assign massReq = state == ST_IDLE && massCmd && unlocked && massEnable;
   assign startPage = (pageReq && pageOk) || (state == ST_IDLE && extPageCmd && pageOk);
   assign startMass = massReq && fromDebugger;
   assign finish = state != ST_IDLE && count == CW'(1);
   // Core idles while erasing; the clock itself is never gated
   assign coreStall = state != ST_IDLE;
   assign eraseBusy = state != ST_IDLE;
   // In bypass the flash strobes leave on GPIO so a programmer can watch them
   assign gpioFlashBusy = bypass && (state != ST_IDLE || extProg);

   // -----------------------------------------
   // Sequencer
   // -----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         count <= '0;
         erasePage <= '0;
         unlocked <= 1'b0;
         eraseDone <= 1'b0;
         refused <= 1'b0;
         extEraseLast <= 1'b0;
      end else begin
         extEraseLast <= extErase;
         eraseDone <= finish;
         refused <= (pageReq && !pageOk) || (massReq && !fromDebugger)
            || (state == ST_IDLE && (pageCmd || massCmd) && !startPage && !startMass);
         if (finish) begin
            state <= ST_IDLE;
            count <= '0;
            unlocked <= 1'b0;
         end else if (startMass) begin
            state <= ST_MASS;
            count <= CW'(MASS_CYC);
         end else if (startPage) begin
            state <= ST_PAGE;
            count <= CW'(PAGE_CYC);
            erasePage <= pageSelect;
         end else if (state != ST_IDLE) begin
            count <= count - CW'(1);
         end else if (unlockReq) begin
            unlocked <= 1'b1;
         end
      end
   end

   // Array contents: erase at completion, programming only clears bits
   always_ff @(posedge core_clk) begin
      if (finish) begin
         for (int i = 0; i < PAGES * PAGE_BYTES; i++) begin
            if (state == ST_MASS || i / PAGE_BYTES == int'(erasePage))
               mem[i] <= ERASED_BYTE;
         end
      end else if (progWrite && state == ST_IDLE && unlocked) begin
         mem[progAddr] <= mem[progAddr] & progData;
      end
   end

   always_ff @(posedge core_clk) begin
      readData <= mem[readAddr];
   end

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   property p_lock_after;
      @(posedge core_clk) disable iff (!reset_n) finish |=> !unlocked;
   endproperty
   a_lock_after: assert property (p_lock_after) else $error("not relocked");
   property p_locked_ignored;
      @(posedge core_clk) disable iff (!reset_n)
         (state == ST_IDLE && ctrlWrite && !unlocked) |=> state == ST_IDLE;
   endproperty
   a_locked_ignored: assert property (p_locked_ignored) else $error("locked cmd ran");
   property p_mass_dbg;
      @(posedge core_clk) disable iff (!reset_n)
         ($rose(state == ST_MASS)) |-> $past(fromDebugger);
   endproperty
   a_mass_dbg: assert property (p_mass_dbg) else $error("mass erase from core");
   property p_page_start;
      @(posedge core_clk) disable iff (!reset_n)
         (state == ST_IDLE && pageCmd && unlocked && pageOk && !massCmd) |=> state == ST_PAGE;
   endproperty
   a_page_start: assert property (p_page_start) else $error("page erase not started");
   property p_prot;
      @(posedge core_clk) disable iff (!reset_n)
         (state == ST_IDLE && !pageOk && !massCmd) |=> state != ST_PAGE;
   endproperty
   a_prot: assert property (p_prot) else $error("protected page erased");
   // The core is released in the very cycle the erase reports done
   property p_stall;
      @(posedge core_clk) disable iff (!reset_n) $fell(eraseBusy) |-> !coreStall && eraseDone;
   endproperty
   a_stall: assert property (p_stall) else $error("stall not released");
   // Busy for exactly PAGE_CYC sampled cycles, idle on the next
   property p_busy_len;
      @(posedge core_clk) disable iff (!reset_n)
         (state == ST_IDLE ##1 state == ST_PAGE) |-> ##(PAGE_CYC - 1) eraseBusy ##1 !eraseBusy;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_done;
      @(posedge core_clk) disable iff (!reset_n) finish |=> eraseDone && !eraseBusy;
   endproperty
   a_done: assert property (p_done) else $error("done missing");
   property p_erased;
      @(posedge core_clk) disable iff (!reset_n)
         (finish && state == ST_PAGE) |=> mem[{erasePage, 9'h000}] == ERASED_BYTE
            && mem[{erasePage, 9'h1ff}] == ERASED_BYTE;
   endproperty
   a_erased: assert property (p_erased) else $error("page not erased");
   c_page: cover property (@(posedge core_clk) state == ST_PAGE && finish);
   c_mass: cover property (@(posedge core_clk) state == ST_MASS && finish);
   c_refused: cover property (@(posedge core_clk) refused);
   c_bypass: cover property (@(posedge core_clk) bypass && state == ST_PAGE);
endmodule
`default_nettype wire

// >>> test/fes_core_model.sv
`default_nettype none
// ---------------------------------------
// Core and debugger side of the control port
// ---------------------------------------
module fes_core_model (
   input wire logic core_clk,
   input wire logic eraseBusy,
   output logic ctrlWrite,
   output logic [7:0] ctrlData,
   output logic unlockReq,
   output logic fromDebugger
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle at time zero so nothing is taken during reset
   initial begin
      ctrlWrite = 1'b0;
      ctrlData = 8'h00;
      unlockReq = 1'b0;
      fromDebugger = 1'b0;
   end
   // Unlock pulse first, command byte one cycle later
   task automatic command(input logic dbg, input logic doUnlock, input logic [7:0] cmd);
      @(negedge core_clk);
      fromDebugger <= dbg;
      unlockReq <= doUnlock;
      @(negedge core_clk);
      unlockReq <= 1'b0;
      ctrlWrite <= 1'b1;
      ctrlData <= cmd;
      @(negedge core_clk);
      ctrlWrite <= 1'b0;
   endtask
   // Poll status rather than trust a fixed erase time; bounded so a hang shows
   task automatic pollDone(output int cycles);
      cycles = 0;
      while (eraseBusy === 1'b1 && cycles < 1000) begin
         @(negedge core_clk);
         cycles++;
      end
   endtask
endmodule
`default_nettype wire

// >>> test/tb_fes_flash_erase_sequencer.sv
`default_nettype none
module tb_fes_flash_erase_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   import fes_pkg::*;
   // Short erase times keep the run small
   localparam int PG = 10;
   localparam int MS = 20;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ctrlWrite, fromDebugger, unlockReq, gpioFlashBusy, unlocked;
   logic eraseBusy, eraseDone, refused, coreStall;
   logic [7:0] ctrlData, readData;
   logic [7:0] progData = 8'h00;
   logic massEnable = 1'b0, pageValid = 1'b0, progWrite = 1'b0;
   logic bypassPin = 1'b0, extErasePin = 1'b0, extProgPin = 1'b0;
   logic [2:0] pageSelect = 3'h2;
   logic [3:0] sectorProtect = 4'h0;
   logic [11:0] readAddr = 12'h000, progAddr = 12'h000;
   int badCount = 0;
   int nChecks = 0;
   int cyc;
   fes_flash_erase_sequencer #(.PAGES(8), .SECTORS(4), .PAGE_CYC(PG), .MASS_CYC(MS))
      fes_flash_erase_sequencer_inst (.core_clk, .reset_n, .ctrlWrite, .ctrlData,
      .fromDebugger, .unlockReq, .massEnable, .pageValid, .pageSelect, .sectorProtect,
      .readAddr, .readData, .progWrite, .progAddr, .progData, .bypassPin, .extErasePin,
      .extProgPin, .gpioFlashBusy, .unlocked, .eraseBusy, .eraseDone, .refused, .coreStall);
   fes_core_model fes_core_model_inst (.core_clk, .eraseBusy, .ctrlWrite, .ctrlData,
      .unlockReq, .fromDebugger);
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic endOfTest();
      $display("checks=%0d mismatches=%0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Read data is registered: compare one edge after the address
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      readAddr = a;
      @(negedge core_clk);
      chk(readData, exp);
   endtask
   // Each byte is cleared once only between erases
   // A locked controller ignores the write, so the caller names the outcome
   task automatic prog(input logic [11:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      progWrite = 1'b1;
      progAddr = a;
      @(negedge core_clk);
      progWrite = 1'b0;
      rd(a, exp);
   endtask
   // Busy and stall from the accepted command, then released and relocked
   task automatic runErase(input int len);
      chk(eraseBusy, 1'b1);
      chk(coreStall, 1'b1);
      fes_core_model_inst.pollDone(cyc);
      chk(cyc[15:0], len[15:0]);
      if (cyc >= 1000) endOfTest();
      chk({unlocked, coreStall, eraseDone}, 3'b001);
   endtask
   // ---------------------------------------
   // Main sequence
   // ---------------------------------------
   initial begin
      repeat (5) @(negedge core_clk);
      reset_n = 1'b1;
      chk(eraseBusy, 1'b0);
      massEnable = 1'b1;
      fes_core_model_inst.command(1'b0, 1'b1, CMD_MASS_ERASE);
      chk({refused, eraseBusy}, 2'b10);
      fes_core_model_inst.command(1'b1, 1'b1, CMD_MASS_ERASE);
      runErase(MS);
      for (int a = 0; a < 4096; a++) rd(a[11:0], ERASED_BYTE);
      // Relocked now, so a page command without unlock must be refused
      pageValid = 1'b1;
      fes_core_model_inst.command(1'b0, 1'b0, CMD_PAGE_ERASE);
      chk({refused, eraseBusy}, 2'b10);
      massEnable = 1'b0;
      fes_core_model_inst.command(1'b1, 1'b1, CMD_MASS_ERASE);
      chk({refused, eraseBusy}, 2'b10);
      prog(12'h3ff, 8'h00);
      prog(12'h400, 8'h00);
      prog(12'h5ff, 8'h00);
      prog(12'h600, 8'h00);
      fes_core_model_inst.command(1'b0, 1'b1, CMD_PAGE_ERASE);
      runErase(PG);
      rd(12'h3ff, 8'h00);
      rd(12'h400, ERASED_BYTE);
      rd(12'h5ff, ERASED_BYTE);
      rd(12'h600, 8'h00);
      // Relocked after the erase, so this program attempt must not land
      prog(12'h400, ERASED_BYTE);
      sectorProtect = 4'h8;
      pageSelect = 3'h6;
      fes_core_model_inst.command(1'b0, 1'b1, CMD_PAGE_ERASE);
      chk({refused, eraseBusy}, 2'b10);
      // Bypass: external erase pin goes through a two-flop synchroniser
      sectorProtect = 4'h0;
      pageSelect = 3'h5;
      prog(12'ha10, 8'h00);
      bypassPin = 1'b1;
      extErasePin = 1'b1;
      for (cyc = 0; cyc < 10 && eraseBusy !== 1'b1; cyc++) @(negedge core_clk);
      chk(gpioFlashBusy, 1'b1);
      if (cyc >= 10) endOfTest();
      runErase(PG);
      rd(12'ha10, ERASED_BYTE);
      // Programmer strobe alone shows on GPIO, and no longer once bypass is left
      extProgPin = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(gpioFlashBusy, 1'b1);
      bypassPin = 1'b0;
      repeat (3) @(negedge core_clk);
      chk(gpioFlashBusy, 1'b0);
      endOfTest();
   end
endmodule
`default_nettype wire
